/* rtl/psram_powerup_reset_seq.sv */
// power-up initialization and hardware reset sequencing of the memory core
// Function
// - a restore held low at power-up postpones the init interval until it goes high.
// - during init the device refreshes its array and is ready once init completes.
// - restore low returns the device to standby from any state.
// - a hardware reset restores all configuration registers to their defaults.
// - while restore is low self-refresh stops and array data is invalid.
// - a hardware reset exits hybrid sleep and deep power down.
// - when restore returns high self-refresh resumes with the row counter at default.
`timescale 1ns/1ps
module psram_powerup_reset_seq
    import psram_seq_pkg::*;
#(
    parameter int unsigned INIT_CYCLES = POWER_UP_INIT_CYC,
    parameter int unsigned ROWS = 8192
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_valid_i,
    input wire logic hardware_restore_n_i,
    input wire logic device_select_n_i,
    input wire logic refresh_tick_i,
    input wire logic cfg_we_i,
    input wire logic cfg_sel_i,
    input wire logic [CFG_W-1:0] cfg_wdata_i,
    input wire logic sleep_req_i,
    input wire logic dpd_req_i,
    output logic select_n_o,
    output logic io_allow_o,
    output logic refresh_req_o,
    output logic [ROW_W-1:0] refresh_row_o,
    output seq_status_t status_o,
    output cfg_regs_t cfg_o,
    output logic hybrid_sleep_o,
    output logic deep_pd_o
);
    // pins from outside the clock domain, two flops each
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end
        else
        begin
            sync1_q <= {supply_valid_i, hardware_restore_n_i, device_select_n_i};
            sync2_q <= sync1_q;
        end
    end
    logic supply_ok;
    logic restore_n;
    logic sel_n;
    assign supply_ok = sync2_q[2];
    assign restore_n = sync2_q[1];
    assign sel_n = sync2_q[0];

    // reset stays in force while supply is invalid or restore is low
    logic hold_reset;
    assign hold_reset = !supply_ok || !restore_n;

    seq_state_t state_q;
    logic [31:0] init_cnt_q;
    logic init_done;
    assign init_done = (init_cnt_q == INIT_CYCLES - 1);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            state_q <= ST_RESET;
        else if (hold_reset)
            state_q <= ST_RESET;
        else
        begin
            unique case (state_q)
                ST_RESET: state_q <= ST_INIT;
                ST_INIT: if (init_done) state_q <= ST_READY;
                ST_READY: state_q <= ST_READY;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset || state_q != ST_INIT)
            init_cnt_q <= 32'h0;
        else if (!init_done)
            init_cnt_q <= init_cnt_q + 32'h1;
    end

    // configuration registers fall back to defaults on any hardware reset
    cfg_regs_t cfg_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset)
        begin
            cfg_q.cfg0 <= CFG0_RESET;
            cfg_q.cfg1 <= CFG1_RESET;
        end
        else if (cfg_we_i && state_q == ST_READY)
        begin
            if (cfg_sel_i)
                cfg_q.cfg1 <= cfg_wdata_i;
            else
                cfg_q.cfg0 <= cfg_wdata_i;
        end
    end
    assign cfg_o = cfg_q;

    // low-power states; deep power down also halts refresh
    logic sleep_q;
    logic dpd_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset)
        begin
            sleep_q <= 1'b0;
            dpd_q <= 1'b0;
        end
        else if (state_q == ST_READY)
        begin
            if (sleep_req_i)
                sleep_q <= 1'b1;
            if (dpd_req_i)
                dpd_q <= 1'b1;
            // leaving a low-power state is by hardware reset only here
        end
    end
    assign hybrid_sleep_o = sleep_q;
    assign deep_pd_o = dpd_q;

    // refresh walks rows; in init every cycle refreshes to sweep the array fast
    logic refresh_run;
    assign refresh_run = (state_q == ST_INIT) || (state_q == ST_READY && !dpd_q);
    logic [ROW_W-1:0] row_q;
    logic refresh_q;
    logic refresh_d;
    assign refresh_d = refresh_run && (state_q == ST_INIT || refresh_tick_i);
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset)
        begin
            row_q <= ROW_RESET;
            refresh_q <= 1'b0;
        end
        else
        begin
            refresh_q <= refresh_d;
            if (refresh_d)
                row_q <= (row_q == ROW_W'(ROWS - 1)) ? ROW_RESET : row_q + 1'b1;
        end
    end
    assign refresh_req_o = refresh_q;
    assign refresh_row_o = row_q;

    // array valid only after a full init pass following a reset
    logic valid_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset)
            valid_q <= 1'b0;
        else if (state_q == ST_INIT && init_done)
            valid_q <= 1'b1;
    end

    logic bus_en;
    assign bus_en = (state_q == ST_READY) && !dpd_q;
    // select is masked so the bus engine never starts a transfer too early
    assign select_n_o = bus_en ? sel_n : 1'b1;
    assign io_allow_o = bus_en;

    assign status_o.ready = (state_q == ST_READY);
    assign status_o.refresh_en = refresh_run;
    assign status_o.array_valid = valid_q;
    assign status_o.bus_enable = bus_en;

    chk_init_to_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_INIT && init_done && !hold_reset) |=> status_o.ready)
        else $error("init end did not reach ready");
    chk_reset_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_reset |=> (state_q == ST_RESET && !status_o.ready))
        else $error("restore low did not force standby");
    chk_cfg_default: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_reset |=> (cfg_o.cfg0 == CFG0_RESET && cfg_o.cfg1 == CFG1_RESET))
        else $error("config not at default after reset");
    chk_refresh_halt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_reset |=> (!refresh_req_o && !status_o.array_valid))
        else $error("refresh ran during restore low");
    chk_lowpower_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_reset |=> (!hybrid_sleep_o && !deep_pd_o))
        else $error("low power state survived reset");
    chk_row_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(hold_reset) && !hold_reset) |-> refresh_row_o == ROW_RESET)
        else $error("row counter not restarted");
    chk_select_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q != ST_READY) |-> (select_n_o && !io_allow_o))
        else $error("select passed during init or reset");
    chk_init_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_RESET && !hold_reset) ##1 !hold_reset |=> (state_q == ST_INIT))
        else $error("init interval cut short");
    chk_refresh_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (status_o.ready && !deep_pd_o && !hold_reset && refresh_tick_i) |=> refresh_req_o)
        else $error("refresh tick not served in ready");

    // cycles since the reset condition last stood; saturates so it never wraps to zero
    logic [31:0] since_rst_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || hold_reset)
            since_rst_q <= 32'h0;
        else if (since_rst_q != 32'hffff_ffff)
            since_rst_q <= since_rst_q + 32'h1;
    end
    // one cycle to leave standby, then the full init interval
    chk_init_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(status_o.ready) |-> (since_rst_q == INIT_CYCLES + 1))
        else $error("ready not one init interval after reset");
endmodule // psram_powerup_reset_seq

/* rtl/psram_seq_pkg.sv */
// shared constants and types for the power-up / hardware-reset sequencer
package psram_seq_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // power_up_init_time, longest figure in microseconds
    localparam int unsigned POWER_UP_INIT_TIME_US = 150;
    localparam int unsigned POWER_UP_INIT_CYC = POWER_UP_INIT_TIME_US * CLK_MHZ;
    // restore_pulse_width and restore_to_select_delay in ns (host side figures)
    localparam int unsigned RESTORE_PULSE_WIDTH_NS = 200;
    localparam int unsigned RESTORE_TO_SELECT_DELAY_NS = 400;
    localparam int unsigned RESTORE_PULSE_CYC = (RESTORE_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RESTORE_SELECT_CYC =
        (RESTORE_TO_SELECT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ROW_W = 13;
    localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
    localparam int unsigned CFG_W = 16;
    localparam logic [CFG_W-1:0] CFG0_RESET = 16'h8f1f;
    localparam logic [CFG_W-1:0] CFG1_RESET = 16'h0002;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_INIT,
        ST_READY
    } seq_state_t;

    typedef struct packed {
        logic ready;
        logic refresh_en;
        logic array_valid;
        logic bus_enable;
    } seq_status_t;

    typedef struct packed {
        logic [CFG_W-1:0] cfg0;
        logic [CFG_W-1:0] cfg1;
    } cfg_regs_t;
endpackage

/* verification/psram_host_model.sv */
// host model driving supply, restore and select pins
`timescale 1ns/1ps
module psram_host_model
    import psram_seq_pkg::*;
#(
    parameter int unsigned INIT = 20
)
(
    input wire logic clk_i,
    input wire logic power_on_i,
    input wire logic pulse_req_i,
    input wire logic sel_req_i,
    output logic supply_valid_o,
    output logic restore_n_o,
    output logic select_n_o
);
    int unsigned fall_cnt = 0;
    int unsigned high_cnt = 0;
    initial
    begin
        supply_valid_o = 1'b0;
        restore_n_o = 1'b0;
        select_n_o = 1'b1;
    end
    always @(posedge clk_i)
    begin
        supply_valid_o <= power_on_i;
        if (restore_n_o && pulse_req_i)
            fall_cnt <= 0;
        else if (fall_cnt < 1000)
            fall_cnt <= fall_cnt + 1;
        restore_n_o <= !(pulse_req_i || fall_cnt < RESTORE_PULSE_CYC);
        if (!restore_n_o || !supply_valid_o)
            high_cnt <= 0;
        else if (high_cnt < 1000)
            high_cnt <= high_cnt + 1;
        // margin over init covers the pin synchronisers
        // select drops with the restore pulse, never rides over it
        select_n_o <= !(sel_req_i && power_on_i && !pulse_req_i && high_cnt > INIT + 8
            && fall_cnt >= RESTORE_SELECT_CYC);
    end
endmodule // psram_host_model

/* verification/psram_powerup_reset_seq_bench.sv */
// self-checking bench for the power-up and hardware reset sequencer
`timescale 1ns/1ps
module psram_powerup_reset_seq_bench;
    import psram_seq_pkg::*;
    localparam int unsigned INIT = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pulse_req = 1'b1;
    logic sel_req = 1'b0;
    logic tick = 1'b0;
    logic we = 1'b0;
    logic sel = 1'b0;
    logic [CFG_W-1:0] wdata = '0;
    logic slp = 1'b0;
    logic dpd = 1'b0;
    logic power_on = 1'b1;
    logic sup, rst_pin, cs_n, sel_o, io_o, rq_o, hs_o, dp_o;
    logic [ROW_W-1:0] row_o;
    seq_status_t st_o;
    cfg_regs_t cfg_o;
    logic [CFG_W-1:0] exp0 = CFG0_RESET;
    logic [CFG_W-1:0] exp1 = CFG1_RESET;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 46479;
    int n;
    int pulses;
    int exp_row;
    always #2 clk_i = ~clk_i;
    psram_host_model #(.INIT(INIT)) u_host (.clk_i(clk_i), .power_on_i(power_on),
        .pulse_req_i(pulse_req), .sel_req_i(sel_req), .supply_valid_o(sup),
        .restore_n_o(rst_pin), .select_n_o(cs_n));
    psram_powerup_reset_seq #(.INIT_CYCLES(INIT)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .supply_valid_i(sup), .hardware_restore_n_i(rst_pin), .device_select_n_i(cs_n),
        .refresh_tick_i(tick), .cfg_we_i(we), .cfg_sel_i(sel), .cfg_wdata_i(wdata),
        .sleep_req_i(slp), .dpd_req_i(dpd), .select_n_o(sel_o), .io_allow_o(io_o),
        .refresh_req_o(rq_o), .refresh_row_o(row_o), .status_o(st_o), .cfg_o(cfg_o),
        .hybrid_sleep_o(hs_o), .deep_pd_o(dp_o));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic low_checks();
        chk(st_o.ready, 0);
        chk(cfg_o, {CFG0_RESET, CFG1_RESET});
        chk({rq_o, st_o.refresh_en, st_o.array_valid}, 0);
        chk({hs_o, dp_o}, 0);
        chk(row_o, 0);
        chk({io_o, sel_o}, 2'b01);
    endtask
    task automatic wait_ready();
        n = 0;
        pulses = 0;
        pulse_req = 1'b0;
        while (rst_pin !== 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        while (st_o.ready !== 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
            pulses += (rq_o === 1'b1);
        end
        chk(n >= INIT && n <= INIT + 8, 1);
        chk(pulses >= INIT - 1, 1);
        chk({io_o, st_o.array_valid}, 2'b11);
        chk(row_o, INIT);
    endtask
    // expected {hybrid sleep, deep power down} after the request of pass m
    function automatic logic [1:0] exp_lp(input int m);
        return (m == 0) ? 2'b10 : 2'b01;
    endfunction
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (40) @(negedge clk_i);
        low_checks();
        wait_ready();
        sel_req = 1'b1;
        n = 0;
        while (cs_n !== 1'b0 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        // the pin needs both synchroniser flops before it reaches the bus engine
        @(negedge clk_i);
        chk(sel_o, 1);
        @(negedge clk_i);
        chk(sel_o, 0);
        exp_row = INIT;
        for (int k = 0; k < 40; k++)
        begin
            we = 1'($random(seed));
            sel = 1'($random(seed));
            wdata = CFG_W'($random(seed));
            tick = 1'($random(seed));
            @(negedge clk_i);
            if (we && sel)
                exp1 = wdata;
            else if (we)
                exp0 = wdata;
            exp_row += tick;
            chk(cfg_o, {exp0, exp1});
            chk(rq_o, tick);
            chk(row_o, exp_row);
        end
        we = 1'b0;
        tick = 1'b0;
        for (int m = 0; m < 2; m++)
        begin
            slp = (m == 0);
            dpd = (m == 1);
            @(negedge clk_i);
            slp = 1'b0;
            dpd = 1'b0;
            repeat (3) @(negedge clk_i);
            chk({hs_o, dp_o}, exp_lp(m));
            // select reads high in deep power down; the host pin is itself still high here, inside restore_to_select_delay
            chk(sel_o, m == 1);
            pulse_req = 1'b1;
            we = 1'b1;
            wdata = 16'h1234;
            repeat (6) @(negedge clk_i);
            low_checks();
            we = 1'b0;
            wait_ready();
            // contents count as lost; the host starts again from defaults
            exp0 = CFG0_RESET;
            exp1 = CFG1_RESET;
            chk(cfg_o, {exp0, exp1});
        end
        // a short supply dip gives no sure power-on reset, so a hardware one follows
        we = 1'b1;
        sel = 1'b0;
        wdata = 16'h5a5a;
        @(negedge clk_i);
        we = 1'b0;
        chk(cfg_o.cfg0, 16'h5a5a);
        power_on = 1'b0;
        repeat (6) @(negedge clk_i);
        low_checks();
        power_on = 1'b1;
        pulse_req = 1'b1;
        repeat (2) @(negedge clk_i);
        wait_ready();
        stop_test();
    end
endmodule // psram_powerup_reset_seq_bench
